// ==== rtl/cid_defs.svh ====
// Constants of the current-input channel diagnostics block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef CID_DEFS_SVH
`define CID_DEFS_SVH
`define CID_NCH         8
// Register byte offsets and address windows
`define CID_OFS_DIAG    8'h00
`define CID_OFS_STATUS  8'h04
`define CID_WIN_MEAS    3'h1
`define CID_WIN_CFG     3'h2
`define CID_WIN_LIM     3'h3
// Configuration and status field positions
`define CID_CFG_UPEN    8
`define CID_CFG_LOEN    9
`define CID_CFG_LBEN    10
`define CID_STAT_FLT    8
// Range settings, reset values and data codes
`define CID_RANGE_ZERO  8'h46
`define CID_RANGE_4MA   8'h47
`define CID_UPPER_RST   16'hffff
`define CID_LOWER_RST   16'h0000
`define CID_CODE_ZERO   16'h0000
`define CID_CODE_FULL   16'hffff
// Diagnosis record bytes
`define CID_REC_HEAD    8'h80
`define CID_REC_INPUT   8'h40
`define CID_FC_RECOVER  8'ha0
`define CID_FC_UNDER    8'ha2
`define CID_FC_OVER     8'ha3
`define CID_FC_LINE     8'ha6
`define CID_FC_UPPER    8'ha7
`define CID_FC_LOWER    8'ha8
// Converter codes on the zero-based scale, then the 4 mA rescale factor and its shift
`define CID_RAW_OPEN    18'h1ffff
`define CID_RAW_20MA    17'hf8c8
`define CID_RAW_4MA     17'h031c2
`define CID_SCALE_4MA   17'h13dc4
`define CID_SCALE_SH    16
`endif

// ==== rtl/cid_pkg.sv ====
// Types shared by the diagnostics modules.
// Assumes cid_defs.svh is on the include path.
`include "cid_defs.svh"
package cid_pkg;
    typedef enum logic [2:0] {
        ST_NORMAL, ST_LINE, ST_OVER, ST_UNDER, ST_UPPER, ST_LOWER
    } cid_state_t;

    // Fault byte reported when a channel enters a state
    function automatic logic [7:0] cid_code(input cid_state_t s);
        unique case (s)
            ST_LINE:  return `CID_FC_LINE;
            ST_OVER:  return `CID_FC_OVER;
            ST_UNDER: return `CID_FC_UNDER;
            ST_UPPER: return `CID_FC_UPPER;
            ST_LOWER: return `CID_FC_LOWER;
            default:  return `CID_FC_RECOVER;
        endcase
    endfunction
endpackage

// ==== rtl/cid_eval_if.sv ====
// Carrier between the top module and the channel evaluator.
// Assumes cid_pkg is compiled first.
`timescale 1ns/1ps
`default_nettype none
interface cid_eval_if;
    import cid_pkg::*;
    logic [17:0]  raw;
    logic         range4;
    logic         en_up;
    logic         en_lo;
    logic         en_line;
    logic [15:0]  upper;
    logic [15:0]  lower;
    logic [15:0]  meas;
    cid_state_t   state;
    modport eval (input raw, range4, en_up, en_lo, en_line, upper, lower,
                  output meas, state);
    modport host (output raw, range4, en_up, en_lo, en_line, upper, lower,
                  input meas, state);
endinterface
`default_nettype wire

// ==== rtl/cid_eval.sv ====
// Combinational evaluation of one converter sample.
// Assumes a signed 18-bit zero-based code; positive full scale = open input.
`timescale 1ns/1ps
`default_nettype none
`include "cid_defs.svh"
module cid_eval
    import cid_pkg::*;
(
    cid_eval_if.eval e
);
    wire        neg     = e.raw[17];
    wire [16:0] mag     = e.raw[16:0];
    wire        open_in = (e.raw == `CID_RAW_OPEN);
    wire        is_line = e.en_line & (neg | open_in);
    wire        is_over = ~neg & (mag > `CID_RAW_20MA);
    wire        below4  = neg | (mag < `CID_RAW_4MA);
    wire        is_undr = e.range4 & ~neg & (mag < `CID_RAW_4MA);

    // Rescale to the 4 mA span; fixed-point ratio trades a code of error
    wire [16:0] off4    = mag - `CID_RAW_4MA;
    wire [33:0] prod    = {17'h0, off4} * {17'h0, `CID_SCALE_4MA};
    wire [17:0] scaled  = prod[33:`CID_SCALE_SH];
    wire [15:0] meas4   = below4 ? `CID_CODE_ZERO :
                          (|scaled[17:16]) ? `CID_CODE_FULL : scaled[15:0];
    wire [15:0] meas0   = neg ? `CID_CODE_ZERO :
                          mag[16] ? `CID_CODE_FULL : mag[15:0];
    wire [15:0] meas_r  = e.range4 ? meas4 : meas0;
    assign e.meas = is_line ? `CID_CODE_ZERO : meas_r;

    wire        is_up   = e.en_up & (e.meas > e.upper);
    wire        is_lo   = e.en_lo & (e.meas < e.lower);

    assign e.state = is_line ? ST_LINE  :
                     is_over ? ST_OVER  :
                     is_undr ? ST_UNDER :
                     is_up   ? ST_UPPER :
                     is_lo   ? ST_LOWER : ST_NORMAL;
endmodule
`default_nettype wire

// ==== rtl/cid_top.sv ====
// Eight-channel current-input diagnostics with an APB register slave.
// Assumes converter samples arrive one channel at a time, synchronous.
// A sample is a signed 18-bit code on the zero-based scale; an open
// input drives the converter to positive full scale.
// Software reads the diagnosis word until it reads zero to drain records.
//
// What this block does
// - Over range reported once on entry, one recovery on return.
// - Data follows current, saturates at full scale, zero below minimum.
// - Above 20 mA in either range, report over range code.
// - In 4 mA range, 0 up to below 4 mA gives under range and zero data.
// - Zero-based range never reports under range; negative is line broken.
// - Return to normal after any fault reports the recovery code.
// - Between 20 mA and full scale, data keeps the proportional code.
// - Distinct codes for exceeding upper and falling below lower limit.
// - Over-limit means code strictly above upper or strictly below lower.
// - Over-limit does not clamp the measured data.
// - Over-limit reported once on entry, one recovery on return.
// - Over-limit alarming has per-channel enables, cleared at reset.
// - Over range and over-limit together report only over range.
// - Limits are 16-bit; upper 1 to 65535, lower 0 to 65534.
// - Line broken reports its code and forces data to zero.
// - Line broken when the converter input sits at maximum.
// - Open or reverse-current input counts as line broken.
// - Line-broken alarming has a per-channel enable, off at reset.
// - Line broken reported once, one recovery when restored.
// - Record is header, input/channel byte, fault byte.
// - Range setting 70 selects zero-based, 71 the 4 mA span.
`timescale 1ns/1ps
`default_nettype none
`include "cid_defs.svh"
module cid_top
    import cid_pkg::*;
#(
    parameter int NCH = `CID_NCH
)
(
    input  wire logic                   REF_CLK_I,
    input  wire logic                   RST_I,
    input  wire logic                   PSEL_I,
    input  wire logic                   PENABLE_I,
    input  wire logic                   PWRITE_I,
    input  wire logic [7:0]             PADDR_I,
    input  wire logic [31:0]            PWDATA_I,
    output logic      [31:0]            PRDATA_O,
    output logic                        PREADY_O,
    output logic                        PSLVERR_O,
    input  wire logic                   ADC_VALID_I,
    input  wire logic [$clog2(NCH)-1:0] ADC_CH_I,
    input  wire logic [17:0]            ADC_CODE_I,
    output logic                        DIAG_PEND_O
);
    localparam int CHW = $clog2(NCH);

    ////////////////////////////////////////////////////////////////////
    // State
    ////////////////////////////////////////////////////////////////////
    // Per-channel configuration
    logic [7:0]      range_ff [NCH];
    logic [NCH-1:0]  upen_ff;
    logic [NCH-1:0]  loen_ff;
    logic [NCH-1:0]  lben_ff;
    logic [15:0]     upper_ff [NCH];
    logic [15:0]     lower_ff [NCH];

    // Per-channel results and reporting state
    logic [15:0]     meas_ff  [NCH];
    cid_state_t      last_ff  [NCH];
    logic [7:0]      code_ff  [NCH];
    logic [NCH-1:0]  pend_ff;
    logic [NCH-1:0]  nxt_pend;

    // Bus side
    logic            pready_ff;
    logic            perr_ff;
    logic [31:0]     prdata_ff;
    logic            pop_vld_ff;
    logic [CHW-1:0]  pop_ch_ff;
    logic            diag_pend_ff;

    ////////////////////////////////////////////////////////////////////
    // Sample evaluation
    ////////////////////////////////////////////////////////////////////
    // One shared evaluator: samples come one channel at a time, so eight
    // copies would only add area and compare logic.
    cid_eval_if ev ();

    // The evaluator sees the settings of the sampled channel, so a config
    // write applies from the next sample on; a record already pending
    // takes the fault byte of any later change on its channel.
    wire [CHW-1:0] sch = ADC_CH_I;

    assign ev.range4  = (range_ff[sch] == `CID_RANGE_4MA);
    assign ev.raw     = ADC_CODE_I;
    assign ev.en_up   = upen_ff[sch];
    assign ev.en_lo   = loen_ff[sch];
    assign ev.en_line = lben_ff[sch];
    assign ev.upper   = upper_ff[sch];
    assign ev.lower   = lower_ff[sch];

    cid_eval u_eval (
        .e (ev.eval)
    );

    wire chg = ADC_VALID_I & (ev.state != last_ff[sch]);

    // Measured data and last reported state per channel
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                meas_ff[i] <= `CID_CODE_ZERO;
                last_ff[i] <= ST_NORMAL;
                // Never shown: nothing is pending after reset
                code_ff[i] <= `CID_FC_RECOVER;
            end
        end
        else if (ADC_VALID_I)
        begin
            meas_ff[sch] <= ev.meas;
            if (chg)
            begin
                last_ff[sch] <= ev.state;
                code_ff[sch] <= cid_code(ev.state);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB decode
    ////////////////////////////////////////////////////////////////////
    // Register map, byte addresses, one aligned 32-bit word each:
    //   0x00       diagnosis record, read only; a read pops what it shows
    //   0x04       status, read only: [7:0] pending, [15:8] in fault
    //   0x20+4*ch  measured data of a channel, read only, [15:0]
    //   0x40+4*ch  config: [7:0] range, [8] upper alarm enable,
    //              [9] lower alarm enable, [10] line-broken enable
    //   0x60+4*ch  limits: [31:16] upper, [15:0] lower
    // Address bits [7:5] pick the window and [4:2] the channel.
    // Refused with an error and no effect: unmapped or unaligned words,
    // channels at or past NCH, and any write to a read-only word.
    // A limit field outside its span (upper 0, lower 0xffff) keeps its old
    // value without an error, so one write can still move the other field.
    // Software drains records by reading 0x00 until it reads zero; the
    // status word shows the same pending bits without popping any.

    wire [2:0]     win     = PADDR_I[7:5];
    wire [CHW-1:0] ach     = PADDR_I[2 +: CHW];
    wire           ch_ok   = (PADDR_I[1:0] == 2'h0) && (int'(PADDR_I[4:2]) < NCH);
    wire           hit_dg  = (PADDR_I == `CID_OFS_DIAG);
    wire           hit_st  = (PADDR_I == `CID_OFS_STATUS);
    wire           hit_ms  = ch_ok & (win == `CID_WIN_MEAS);
    wire           hit_cf  = ch_ok & (win == `CID_WIN_CFG);
    wire           hit_lm  = ch_ok & (win == `CID_WIN_LIM);
    // Read-only and writable windows
    wire           hit_ro  = hit_dg | hit_st | hit_ms;
    wire           hit_rw  = hit_cf | hit_lm;
    // Writes to read-only words are refused as errors too
    wire           bad     = ~(hit_ro | hit_rw) | (PWRITE_I & hit_ro);
    wire           setup   = PSEL_I & ~PENABLE_I;
    wire           fire    = PSEL_I & PENABLE_I & pready_ff;
    wire           wr_ok   = fire & PWRITE_I & ~perr_ff;
    wire           wr_cf   = wr_ok & hit_cf;
    wire           wr_lm   = wr_ok & hit_lm;

    // Lowest pending channel offered to the next diagnosis read
    // Fixed priority; each read pops one record, so no channel waits long
    logic           first_vld;
    logic [CHW-1:0] first_ch;
    always_comb
    begin
        first_vld = 1'b0;
        first_ch  = '0;
        for (int i = NCH - 1; i >= 0; i--)
        begin
            if (pend_ff[i])
            begin
                first_vld = 1'b1;
                first_ch  = CHW'(i);
            end
        end
    end

    wire [7:0]  rec_chan = `CID_REC_INPUT | 8'(first_ch);
    wire [31:0] diag_wd  = first_vld ?
                           {8'h0, `CID_REC_HEAD, rec_chan, code_ff[first_ch]} : 32'h0;

    // Status: pending records and channels currently in fault
    logic [31:0] stat_wd;
    always_comb
    begin
        stat_wd = 32'h0;
        for (int i = 0; i < NCH; i++)
        begin
            stat_wd[i]                 = pend_ff[i];
            stat_wd[`CID_STAT_FLT + i] = (last_ff[i] != ST_NORMAL);
        end
    end

    wire [31:0] cfg_wd = {21'h0, lben_ff[ach], loen_ff[ach], upen_ff[ach], range_ff[ach]};
    wire [31:0] lim_wd = {upper_ff[ach], lower_ff[ach]};
    wire [31:0] rd_val = hit_dg ? diag_wd :
                         hit_st ? stat_wd :
                         hit_ms ? {16'h0, meas_ff[ach]} :
                         hit_cf ? cfg_wd :
                         hit_lm ? lim_wd : 32'h0;

    ////////////////////////////////////////////////////////////////////
    // APB handshake: no wait state, read data latched in setup
    ////////////////////////////////////////////////////////////////////
    // The setup edge decodes the address and latches the answer; ready,
    // read data and error then stand for the one access cycle. A write
    // lands at the edge that ends the access cycle. Answering from flops
    // keeps the decode off the pin path at the cost of a fixed answer time.
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            pready_ff  <= 1'b0;
            perr_ff    <= 1'b0;
            prdata_ff  <= 32'h0;
            pop_vld_ff <= 1'b0;
            pop_ch_ff  <= '0;
        end
        else
        begin
            pready_ff <= setup;
            // Error rises only with ready, so the pin comes straight from it
            perr_ff   <= setup & bad;
            if (setup)
            begin
                prdata_ff  <= (PWRITE_I | bad) ? 32'h0 : rd_val;
                pop_vld_ff <= ~PWRITE_I & hit_dg & first_vld;
                pop_ch_ff  <= first_ch;
            end
            else if (fire)
            begin
                pop_vld_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration registers
    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            upen_ff <= '0;
            loen_ff <= '0;
            lben_ff <= '0;
            for (int i = 0; i < NCH; i++)
            begin
                range_ff[i] <= `CID_RANGE_ZERO;
                upper_ff[i] <= `CID_UPPER_RST;
                lower_ff[i] <= `CID_LOWER_RST;
            end
        end
        else
        begin
            // range byte kept as written; only 71 selects the 4 mA span
            if (wr_cf)
            begin
                range_ff[ach] <= PWDATA_I[7:0];
                upen_ff[ach]  <= PWDATA_I[`CID_CFG_UPEN];
                loen_ff[ach]  <= PWDATA_I[`CID_CFG_LOEN];
                lben_ff[ach]  <= PWDATA_I[`CID_CFG_LBEN];
            end
            // Upper above lower is software's duty and is not checked here
            // out-of-range limit ignored
            if (wr_lm && PWDATA_I[31:16] != 16'h0)
            begin
                upper_ff[ach] <= PWDATA_I[31:16];
            end
            if (wr_lm && PWDATA_I[15:0] != 16'hffff)
            begin
                lower_ff[ach] <= PWDATA_I[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pending records
    ////////////////////////////////////////////////////////////////////
    // A channel stays pending until its record is read; a later transition
    // on the same channel before the read overwrites the fault byte, so
    // software sees the newest state, except for a change at the read's setup edge, whose byte the read pops unseen.
    wire pop = fire & pop_vld_ff;

    // new change sets pending; a set in the pop cycle wins
    always_comb
    begin
        nxt_pend = pend_ff;
        for (int i = 0; i < NCH; i++)
        begin
            if (pop && pop_ch_ff == CHW'(i))
            begin
                nxt_pend[i] = 1'b0;
            end
            if (chg && sch == CHW'(i))
            begin
                nxt_pend[i] = 1'b1;
            end
        end
    end

    // Pending bits and their summary flop share one next value, so the
    // pin never lags the bits and needs no gate after the flop.
    // pending kept until popped
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            pend_ff      <= '0;
            diag_pend_ff <= 1'b0;
        end
        else
        begin
            pend_ff      <= nxt_pend;
            diag_pend_ff <= |nxt_pend;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////
    // All pins are flop outputs; error is only ever high with ready
    assign PRDATA_O    = prdata_ff;
    assign PREADY_O    = pready_ff;
    assign PSLVERR_O   = perr_ff;
    assign DIAG_PEND_O = diag_pend_ff;
endmodule
`default_nettype wire

// ==== tb/cid_top_properties.sv ====
// Checker on the top ports: APB timing and diagnosis word shape.
// Assumes it is bound into cid_top and sees one clock domain.
`timescale 1ns/1ps
`default_nettype none
module cid_chk #(
    parameter int NCH = 8
)
(
    input wire logic                   REF_CLK_I,
    input wire logic                   RST_I,
    input wire logic                   PSEL_I,
    input wire logic                   PENABLE_I,
    input wire logic                   PWRITE_I,
    input wire logic [7:0]             PADDR_I,
    input wire logic [31:0]            PWDATA_I,
    input wire logic [31:0]            PRDATA_O,
    input wire logic                   PREADY_O,
    input wire logic                   PSLVERR_O,
    input wire logic                   ADC_VALID_I,
    input wire logic [$clog2(NCH)-1:0] ADC_CH_I,
    input wire logic [17:0]            ADC_CODE_I,
    input wire logic                   DIAG_PEND_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    // Decoded bus phases
    wire setup   = PSEL_I && !PENABLE_I;
    wire diag_rd = PREADY_O && !PWRITE_I && PADDR_I == 8'h00 && !PSLVERR_O;
    ////////////////////////////////////////////////////////////////////////////
    a_ready_after_setup: assert property (setup |=> PREADY_O)
        else $error("no ready after setup");
    a_ready_one_pulse: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    a_err_needs_ready: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    a_ro_write_refused: assert property (setup && PWRITE_I && PADDR_I == 8'h00 |=> PSLVERR_O)
        else $error("write to diag word not refused");
    a_write_reads_zero: assert property (PREADY_O && PWRITE_I |-> PRDATA_O == 32'h0)
        else $error("read data on write");
    a_diag_word_shape: assert property (diag_rd && PRDATA_O != 32'h0 |->
        PRDATA_O[31:16] == 16'h0080 && PRDATA_O[15:11] == 5'b01000)
        else $error("diag word header or channel byte wrong");
    a_diag_code_legal: assert property (diag_rd && PRDATA_O != 32'h0 |->
        PRDATA_O[7:0] inside {8'ha0, 8'ha2, 8'ha3, 8'ha6, 8'ha7, 8'ha8})
        else $error("illegal fault byte");
    // Pending may only rise after a sample and only fall after a pop
    a_pend_from_sample: assert property ($rose(DIAG_PEND_O) |->
        $past(ADC_VALID_I) || $past(ADC_VALID_I, 2))
        else $error("pending raised without sample");
    a_pend_clear_pop: assert property ($fell(DIAG_PEND_O) |->
        $past(diag_rd) || $past(diag_rd, 2))
        else $error("pending dropped without pop");
    c_line_report: cover property (diag_rd && PRDATA_O[7:0] == 8'ha6);
    c_refused: cover property (PSLVERR_O);
    c_pend_rise: cover property ($rose(DIAG_PEND_O));
endmodule
bind cid_top cid_chk #(.NCH(NCH)) u_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .ADC_VALID_I(ADC_VALID_I), .ADC_CH_I(ADC_CH_I),
    .ADC_CODE_I(ADC_CODE_I), .DIAG_PEND_O(DIAG_PEND_O));
`default_nettype wire

// ==== tb/cid_adc_model.sv ====
// Converter model: turns a bench request into a one-cycle sample.
// Assumes requests are one cycle wide and change after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module cid_adc_model (
    input  wire logic        clk_i,
    input  wire logic        req_i,
    input  wire logic        open_i,
    input  wire logic [2:0]  ch_i,
    input  wire logic [17:0] code_i,
    output logic             valid_o,
    output logic [2:0]       ch_o,
    output logic [17:0]      code_o
);
    initial
    begin
        valid_o = 1'b0;
        ch_o = 3'h0;
        code_o = 18'h0;
    end
    // Code lines toggle between samples so stale data never looks valid
    // open input sits at maximum
    always @(posedge clk_i)
    begin
        valid_o <= req_i;
        ch_o <= ch_i;
        code_o <= !req_i ? ~code_o : (open_i ? 18'h1ffff : code_i);
    end
endmodule
`default_nettype wire

// ==== tb/cid_top_tb_top.sv ====
// Self-checking bench: APB register tasks and converter samples.
// Assumes cid_top, the converter model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module cid_top_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        req = 1'b0;
    logic        open_in = 1'b0;
    logic [2:0]  s_ch = 3'h0;
    logic [17:0] s_code = 18'h0;
    logic        a_valid;
    logic [2:0]  a_ch;
    logic [17:0] a_code;
    logic        pend;
    logic [31:0] r;
    logic        e;
    int          failures = 0;
    int          n_checks = 0;
    int          cycles = 0;
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    cid_top dut (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .ADC_VALID_I(a_valid),
        .ADC_CH_I(a_ch), .ADC_CODE_I(a_code), .DIAG_PEND_O(pend));
    cid_adc_model u_adc (.clk_i(clk), .req_i(req), .open_i(open_in), .ch_i(s_ch),
        .code_i(s_code), .valid_o(a_valid), .ch_o(a_ch), .code_o(a_code));
    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        begin
            if (failures == 0 && n_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        begin
            n_checks++;
            if (s !== x)
            begin
                failures++;
                $display("mismatch %s expected %h seen %h", nm, x, s);
            end
        end
    endtask
    // One APB transfer; waits on ready, bounded
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        begin
            n = 0;
            @(posedge clk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1 && n < 20)
            begin
                @(posedge clk);
                n++;
            end
            if (n >= 20)
                failures++;
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] x);
        begin
            apb(1'b0, a, 32'h0);
            chk($sformatf("reg %h", a), r, x);
        end
    endtask
    task automatic sample(input logic [2:0] c, input logic [17:0] x, input logic o);
        begin
            @(posedge clk);
            req <= 1'b1;
            s_ch <= c;
            s_code <= x;
            open_in <= o;
            @(posedge clk);
            req <= 1'b0;
            @(posedge clk);
        end
    endtask
    // Sample, then read data and the next record; fb 0 means none
    task automatic step(input logic [2:0] c, input logic [17:0] x, input logic o,
                        input logic [15:0] m, input logic [7:0] fb);
        begin
            sample(c, x, o);
            rc(8'h20 + {3'h0, c, 2'b00}, {16'h0, m});
            rc(8'h00, (fb == 8'h00) ? 32'h0 : {16'h0080, 5'b01000, c, fb});
        end
    endtask
    // Hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            failures++;
            give_verdict;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rc(8'h40, 32'h0000_0046);
        rc(8'h7c, 32'hffff_0000);
        rc(8'h00, 32'h0);
        apb(1'b0, 8'h80, 32'h0);
        chk("unmapped err", {31'h0, e}, 32'h1);
        apb(1'b0, 8'h21, 32'h0);
        chk("unaligned err", {31'h0, e}, 32'h1);
        apb(1'b1, 8'h00, 32'h1);
        chk("ro write err", {31'h0, e}, 32'h1);
        // Zero-based over range, channel 2
        step(3'd2, 18'h0f8c9, 1'b0, 16'hf8c9, 8'ha3);
        step(3'd2, 18'h0f8c9, 1'b0, 16'hf8c9, 8'h00);
        step(3'd2, 18'h11170, 1'b0, 16'hffff, 8'h00);
        step(3'd2, 18'h07530, 1'b0, 16'h7530, 8'ha0);
        step(3'd2, 18'h0f8c8, 1'b0, 16'hf8c8, 8'h00);
        // 4 mA span, channel 1
        apb(1'b1, 8'h44, 32'h47);
        step(3'd1, 18'h031c1, 1'b0, 16'h0000, 8'ha2);
        step(3'd1, 18'h0f8c8, 1'b0, 16'hf70a, 8'ha0);
        step(3'd1, 18'h11170, 1'b0, 16'hffff, 8'ha3);
        step(3'd1, 18'h031c2, 1'b0, 16'h0000, 8'ha0);
        // Line broken, channel 3; unused channels keep it off
        step(3'd3, 18'h3fff0, 1'b0, 16'h0000, 8'h00);
        apb(1'b1, 8'h4c, 32'h446);
        step(3'd3, 18'h3fff0, 1'b0, 16'h0000, 8'ha6);
        step(3'd3, 18'h3fff0, 1'b1, 16'h0000, 8'h00);
        step(3'd3, 18'h003e8, 1'b0, 16'h03e8, 8'ha0);
        step(3'd3, 18'h00000, 1'b1, 16'h0000, 8'ha6);
        // Limits, channel 4, upper above lower
        apb(1'b1, 8'h70, 32'hba96_31c1);
        apb(1'b1, 8'h50, 32'h346);
        step(3'd4, 18'h0ba96, 1'b0, 16'hba96, 8'h00);
        step(3'd4, 18'h0ba97, 1'b0, 16'hba97, 8'ha7);
        step(3'd4, 18'h0ba97, 1'b0, 16'hba97, 8'h00);
        step(3'd4, 18'h031c1, 1'b0, 16'h31c1, 8'ha0);
        step(3'd4, 18'h031c0, 1'b0, 16'h31c0, 8'ha8);
        step(3'd4, 18'h0f8c9, 1'b0, 16'hf8c9, 8'ha3);
        step(3'd4, 18'h07530, 1'b0, 16'h7530, 8'ha0);
        apb(1'b1, 8'h50, 32'h46);
        step(3'd4, 18'h031c0, 1'b0, 16'h31c0, 8'h00);
        apb(1'b1, 8'h70, 32'h0000_0005);
        rc(8'h70, 32'hba96_0005);
        // Two records pending, lowest channel pops first
        sample(3'd6, 18'h0f8c9, 1'b0);
        sample(3'd5, 18'h0f8c9, 1'b0);
        rc(8'h04, 32'h0000_6860);
        chk("pend pin", {31'h0, pend}, 32'h1);
        rc(8'h00, 32'h0080_45a3);
        rc(8'h00, 32'h0080_46a3);
        rc(8'h04, 32'h0000_6800);
        chk("pend pin", {31'h0, pend}, 32'h0);
        give_verdict;
    end
endmodule
`default_nettype wire
